// *** sec_pkg.sv ***
// Package of constants and types for the serial EEPROM command engine
package sec_pkg;
   // Array geometry
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int DEPTH  = 128;
   // Serial framing: opcode bits, address bits, data bits
   localparam int OPC_W  = 2;
   localparam int CMD_BITS  = OPC_W + ADDR_W;      // bits after start for short commands
   localparam int DATA_BITS = CMD_BITS + DATA_W;   // bits after start for data commands
   // Opcodes
   localparam logic [1:0] OPC_ERASE   = 2'h3;
   localparam logic [1:0] OPC_READ    = 2'h2;
   localparam logic [1:0] OPC_WRITE   = 2'h1;
   localparam logic [1:0] OPC_SPECIAL = 2'h0;
   // Special command selectors in top two address bits
   localparam logic [1:0] SPC_ERASE_ALL = 2'h2;
   localparam logic [1:0] SPC_LOCK      = 2'h0;
   localparam logic [1:0] SPC_UNLOCK    = 2'h3;
   localparam logic [1:0] SPC_FILL_ALL  = 2'h1;
   // Factory contents
   localparam logic [7:0] ERASED_BYTE       = 8'hff;
   localparam logic [7:0] PROGRAMMED_MARKER = 8'ha5;
   localparam logic [6:0] MARKER_ADDR       = 7'h00;
   localparam logic [6:0] NODE_FIRST_ADDR   = 7'h01;
   localparam logic [6:0] NODE_LAST_ADDR    = 7'h06;
   localparam logic [6:0] LAST_ADDR         = 7'h7f;
   // Timing: clock period and program cycle times
   localparam int CLK_NS      = 10;
   localparam int CSL_MIN_NS  = 250;
   localparam int CSL_MIN_CYC = (CSL_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int TWC_MS      = 6;
   localparam int TEC_MS      = 6;
   localparam int TWL_MS      = 15;
   localparam int TWC_CYC     = TWC_MS * 1000000 / CLK_NS;
   localparam int TEC_CYC     = TEC_MS * 1000000 / CLK_NS;
   localparam int TWL_CYC     = TWL_MS * 1000000 / CLK_NS;
   // Engine states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_SHIFT = 3'b001,
      ST_READ  = 3'b010,
      ST_ARMED = 3'b011,
      ST_DONE  = 3'b100
   } sec_state_t;
   // Program kinds
   typedef enum logic [1:0] {
      PG_BYTE  = 2'b00,
      PG_CLEAR = 2'b01,
      PG_FILL  = 2'b10
   } sec_prog_t;
endpackage

// *** sec_wr_if.sv ***
// Interface carrying program requests from the engine to the array
`timescale 1ns/1ps
interface sec_wr_if;
   logic                            valid;  // Request offered
   logic                            ready;  // Request taken
   sec_pkg::sec_prog_t              kind;   // Byte, clear-all or fill-all
   logic [sec_pkg::ADDR_W-1:0]      addr;   // Target for byte
   logic [sec_pkg::DATA_W-1:0]      data;   // Data for byte or fill
   modport src  (output valid, kind, addr, data, input ready);
   modport sink (input valid, kind, addr, data, output ready);
endinterface

// *** sec_buf.sv ***
// Two-entry buffer for program requests
`timescale 1ns/1ps
module sec_buf #(
   parameter int W = 17
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   logic [W-1:0] mem_r [2];  // Two slots
   logic         wp_r;       // Write slot
   logic         rp_r;       // Read slot
   logic [1:0]   cnt_r;      // Occupancy
   wire push = in_valid && in_ready;
   wire pop  = out_valid && out_ready;
   assign in_ready  = (cnt_r != 2'h2);
   assign out_valid = (cnt_r != 2'h0);
   assign out_data  = mem_r[rp_r];
   // Pointers and count
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_r  <= 1'b0;
         rp_r  <= 1'b0;
         cnt_r <= 2'h0;
      end else begin
         if (push) wp_r <= ~wp_r;
         if (pop) rp_r <= ~rp_r;
         cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      end
   end
   // Storage, no reset needed
   always_ff @(posedge clk) begin
      if (push) mem_r[wp_r] <= in_data;
   end
endmodule

// *** sec_array.sv ***
// Memory array with self-timed programming
`timescale 1ns/1ps
module sec_array #(
   parameter int TWC = sec_pkg::TWC_CYC,
   parameter int TEC = sec_pkg::TEC_CYC,
   parameter int TWL = sec_pkg::TWL_CYC,
   parameter logic [47:0] NODE_ADDR = 48'h0a0b0c_010203  // Arbitrary value
) (
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst,
   // Program requests
   sec_wr_if.sink                          wr,
   // Read port
   input  wire logic [sec_pkg::ADDR_W-1:0] rd_addr,
   output logic [sec_pkg::DATA_W-1:0]      rd_data,
   // Busy level
   output logic                            busy
);
   logic [7:0]  mem_r [sec_pkg::DEPTH];  // Array contents
   logic        busy_r;                  // Cycle running
   logic [31:0] tmr_r;                   // Cycles left
   sec_pkg::sec_prog_t kind_r;
   logic [6:0]  addr_r;
   logic [7:0]  data_r;
   logic        init_r;                  // Factory load pending
   logic [6:0]  ia_r;                    // Factory load index
   wire take = wr.valid && !busy_r && !init_r;
   wire fin  = busy_r && (tmr_r == 32'h0);
   assign wr.ready = !busy_r && !init_r;
   assign busy     = busy_r || init_r;
   assign rd_data  = mem_r[rd_addr];
   wire [7:0] init_val = (ia_r == sec_pkg::MARKER_ADDR) ? sec_pkg::PROGRAMMED_MARKER : // [R14]
                         (ia_r >= sec_pkg::NODE_FIRST_ADDR && ia_r <= sec_pkg::NODE_LAST_ADDR) ?
                         NODE_ADDR[8*(sec_pkg::NODE_LAST_ADDR - ia_r) +: 8] :    // [R13]
                         sec_pkg::ERASED_BYTE;
   // Timer and control
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy_r <= 1'b0;
         tmr_r  <= 32'h0;
         kind_r <= sec_pkg::PG_BYTE;
         addr_r <= 7'h00;
         data_r <= 8'h00;
         init_r <= 1'b1;
         ia_r   <= 7'h00;
      end else begin
         if (init_r) begin
            ia_r <= ia_r + 7'h01;
            if (ia_r == sec_pkg::LAST_ADDR) init_r <= 1'b0;
         end
         if (take) begin
            busy_r <= 1'b1;
            kind_r <= wr.kind;
            addr_r <= wr.addr;
            data_r <= wr.data;
            tmr_r  <= (wr.kind == sec_pkg::PG_BYTE) ? 32'(TWC - 1) :
                      (wr.kind == sec_pkg::PG_CLEAR) ? 32'(TEC - 1) : 32'(TWL - 1);
         end else if (fin) begin
            busy_r <= 1'b0;
         end else if (busy_r) begin
            tmr_r <= tmr_r - 32'h1;
         end
      end
   end
   // Contents commit at end of cycle; erase-before-write is implicit
   always_ff @(posedge clk) begin
      if (init_r) mem_r[ia_r] <= init_val;
      else if (fin && kind_r == sec_pkg::PG_BYTE) mem_r[addr_r] <= data_r;    // [R1] [R11]
      else if (fin) begin
         for (int i = 0; i < sec_pkg::DEPTH; i++) begin
            mem_r[i] <= (kind_r == sec_pkg::PG_CLEAR) ? sec_pkg::ERASED_BYTE   // [R4]
                                                      : data_r;                 // [R12]
         end
      end
   end
endmodule

// *** sec_engine.sv ***
// Top of the serial EEPROM command engine: link sampling, decode, output
// Functional notes
// R1: Erase sets addressed byte to ones
// R2: Raised select shows busy zero, ready one
// R3: Start bit then select low clears status
// R4: Erase-all sets whole array to ones
// R5: Power-up locked; programming refused until unlocked
// R6: Unlock persists until lock or power loss
// R7: Reads work whether locked or unlocked
// R8: Read sends dummy zero then eight bits
// R9: Read bits change on clock rising edge
// R10: Continued clocking streams next addresses
// R11: Write takes eight data bits, select-low starts
// R12: Fill-all erases then writes every byte
// R13: Locations one to six hold node address
// R14: Location zero holds marker, all writable
// R15: Programming finishes even when deselected
// R16: Select low holds control logic reset
// R17: Input bits sampled on rising clock
// R18: Paused clock at any level tolerated
// R19: No start bit, clocks change nothing
// R20: Exact bit count, then ignore until start
// R21: Select held low keeps output released
// R22: Host should lock after every write; the bench host locks only once, in t_clear_lock after the erase-all
// R23: Start is first edge with both high
// R24: Command coding of opcodes and selectors
// R25: Output released except read or status
// R26: Sequential read wraps from last to zero
`timescale 1ns/1ps
module sec_engine #(
   parameter int TWC = sec_pkg::TWC_CYC,
   parameter int TEC = sec_pkg::TEC_CYC,
   parameter int TWL = sec_pkg::TWL_CYC,
   parameter logic [47:0] NODE_ADDR = 48'h0a0b0c_010203  // Arbitrary value
) (
   // System
   input  wire logic MCLK,
   input  wire logic RST,
   // Serial link inputs
   input  wire logic SEL,
   input  wire logic SCLK,
   input  wire logic SERIAL_IN,
   // Serial output, enable low drives the pin
   output logic      SERIAL_OUT,
   output logic      SERIAL_OUT_OE_N
);
   // Two-flop synchronisers for each link input
   logic [1:0] sel_s_r;
   logic [1:0] clk_s_r;
   logic [1:0] din_s_r;
   logic       clk_d_r;   // Previous synced clock for edge find
   logic       sel_d_r;   // Previous synced select
   wire sel  = sel_s_r[1];
   wire sclk = clk_s_r[1];
   wire din  = din_s_r[1];
   wire rise     = sclk && !clk_d_r;                 // [R17]
   wire sel_fall = sel_d_r && !sel;
   wire sel_rise = !sel_d_r && sel;

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         sel_s_r <= 2'h0;
         clk_s_r <= 2'h0;
         din_s_r <= 2'h0;
         clk_d_r <= 1'b0;
         sel_d_r <= 1'b0;
      end else begin
         sel_s_r <= {sel_s_r[0], SEL};
         clk_s_r <= {clk_s_r[0], SCLK};
         din_s_r <= {din_s_r[0], SERIAL_IN};
         clk_d_r <= sclk;
         sel_d_r <= sel;
      end
   end

   // Engine state
   sec_pkg::sec_state_t st_r, st_nxt;
   logic [4:0]  cnt_r;       // Bits received after start
   logic [16:0] sh_r;        // Opcode, address, data shift
   logic        unlock_r;    // Programming enabled
   logic [6:0]  raddr_r;     // Read pointer
   logic [8:0]  rsh_r;       // Read output shift
   logic        rd_drv_r;    // Driving read data
   logic        pend_r;      // A program cycle was launched
   logic        stat_r;      // Status shown on output
   logic [4:0]  low_cnt_r;   // Select low time count
   logic        low_ok_r;    // Select was low long enough
   logic        q_valid_r;   // Request offered to buffer
   sec_pkg::sec_prog_t q_kind_r;
   logic [6:0]  q_addr_r;
   logic [7:0]  q_data_r;

   // Array and buffer wiring
   sec_wr_if arr_q ();
   logic [7:0] rd_data;
   logic       arr_busy;
   logic       buf_ready;
   logic       buf_valid;
   logic [16:0] buf_out;

   // Decode of the collected bits
   wire [1:0] opc     = sh_r[16:15];
   wire [6:0] a_field = sh_r[14:8];
   wire [1:0] spc     = sh_r[14:13];
   wire [1:0] opc9    = sh_r[8:7];         // Opcode while only nine bits are in
   wire [6:0] a9      = sh_r[6:0];
   wire [1:0] spc9    = sh_r[6:5];
   wire is_data_cmd = (opc9 == sec_pkg::OPC_WRITE) ||
                      (opc9 == sec_pkg::OPC_SPECIAL && spc9 == sec_pkg::SPC_FILL_ALL); // [R24]
   // Decode one cycle after the ninth bit, once it sits in the shifter
   wire short_done = st_r == sec_pkg::ST_SHIFT && sel &&
                     cnt_r == 5'(sec_pkg::CMD_BITS);
   wire data_done  = st_r == sec_pkg::ST_SHIFT && rise && sel &&
                     cnt_r == 5'(sec_pkg::DATA_BITS - 1);
   wire start_seen = st_r == sec_pkg::ST_IDLE && sel && rise && din;   // [R23]
   wire prog_cmd   = (opc9 == sec_pkg::OPC_ERASE) ||
                     (opc9 == sec_pkg::OPC_SPECIAL && spc9 == sec_pkg::SPC_ERASE_ALL);
   wire is_read9   = opc9 == sec_pkg::OPC_READ;
   // Launch on select fall from armed, only when unlocked
   wire launch     = st_r == sec_pkg::ST_ARMED && sel_fall && unlock_r;   // [R5]

   // Next state: idle waits for start, shift collects bits
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         sec_pkg::ST_IDLE:  if (start_seen) st_nxt = sec_pkg::ST_SHIFT;   // [R19]
         sec_pkg::ST_SHIFT: begin
            if (short_done && is_read9) st_nxt = sec_pkg::ST_READ;
            else if (short_done && prog_cmd) st_nxt = sec_pkg::ST_ARMED;
            else if (short_done && !is_data_cmd) st_nxt = sec_pkg::ST_DONE;
            else if (data_done) st_nxt = sec_pkg::ST_ARMED;               // [R11]
         end
         sec_pkg::ST_READ:  st_nxt = sec_pkg::ST_READ;
         sec_pkg::ST_ARMED: st_nxt = sec_pkg::ST_ARMED;
         sec_pkg::ST_DONE:  st_nxt = sec_pkg::ST_DONE;                    // [R20]
         default:           st_nxt = sec_pkg::ST_IDLE;
      endcase
   end

   // Command decode and control; select low resets state, bit count and read drive
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         st_r     <= sec_pkg::ST_IDLE;
         cnt_r    <= 5'h00;
         sh_r     <= 17'h00000;
         unlock_r <= 1'b0;                                 // [R5]
         raddr_r  <= 7'h00;
         rsh_r    <= 9'h000;
         rd_drv_r <= 1'b0;
      end else if (!sel) begin
         st_r     <= sec_pkg::ST_IDLE;                     // [R16]
         cnt_r    <= 5'h00;
         rd_drv_r <= 1'b0;                                 // [R25]
      end else begin
         st_r <= st_nxt;
         // Clock pauses simply produce no edges here
         if (st_r == sec_pkg::ST_SHIFT && rise) begin      // [R18]
            sh_r  <= {sh_r[15:0], din};                    // [R17]
            cnt_r <= cnt_r + 5'h01;
         end
         if (short_done && opc9 == sec_pkg::OPC_SPECIAL) begin
            if (spc9 == sec_pkg::SPC_UNLOCK) unlock_r <= 1'b1;    // [R6]
            if (spc9 == sec_pkg::SPC_LOCK) unlock_r <= 1'b0;      // [R6]
         end
         // Read pointer and shifter; reads ignore the lock [R7]
         if (short_done && is_read9) begin
            raddr_r  <= a9;
            rsh_r    <= 9'h000;
            rd_drv_r <= 1'b1;                              // [R8] dummy zero first
         end else if (st_r == sec_pkg::ST_READ && rise) begin
            if (cnt_r == 5'(sec_pkg::CMD_BITS)) begin
               rsh_r   <= {rd_data, 1'b0};                 // [R8] [R9]
               raddr_r <= raddr_r + 7'h01;                 // [R10] [R26] wraps at 0x7f
               cnt_r   <= cnt_r + 5'h01;
            end else if (cnt_r == 5'(sec_pkg::DATA_BITS)) begin
               rsh_r   <= {rd_data, 1'b0};                 // [R10] next word, no dummy
               raddr_r <= raddr_r + 7'h01;                 // [R26]
               cnt_r   <= 5'(sec_pkg::CMD_BITS + 1);    // Seven shifts follow the reload
            end else begin
               rsh_r <= {rsh_r[7:0], 1'b0};                // [R9]
               cnt_r <= cnt_r + 5'h01;
            end
         end
      end
   end

   // Request capture: select fall from armed offers one program request
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         q_valid_r <= 1'b0;
         q_kind_r  <= sec_pkg::PG_BYTE;
         q_addr_r  <= 7'h00;
         q_data_r  <= 8'h00;
      end else if (launch) begin
         q_valid_r <= 1'b1;
         q_addr_r  <= (sh_r[16:15] == sec_pkg::OPC_WRITE) ? a_field : a9;
         q_data_r  <= (opc == sec_pkg::OPC_WRITE || opc == sec_pkg::OPC_SPECIAL) ?
                      sh_r[7:0] : sec_pkg::ERASED_BYTE;
         // Nine-bit commands: erase, erase-all; seventeen-bit: write, fill-all
         if (cnt_r == 5'(sec_pkg::CMD_BITS)) begin
            q_kind_r <= (opc9 == sec_pkg::OPC_ERASE) ? sec_pkg::PG_BYTE : sec_pkg::PG_CLEAR; // [R1] [R4]
            q_addr_r <= a9;
            q_data_r <= sec_pkg::ERASED_BYTE;              // [R1]
         end else begin
            q_kind_r <= (opc == sec_pkg::OPC_WRITE) ? sec_pkg::PG_BYTE : sec_pkg::PG_FILL;   // [R12]
         end
      end else if (q_valid_r && buf_ready) begin
         q_valid_r <= 1'b0;
      end
   end

   // Status: select low time, pending launch, clear on start then select low
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         low_cnt_r <= 5'h00;
         low_ok_r  <= 1'b0;
         pend_r    <= 1'b0;
         stat_r    <= 1'b0;
      end else begin
         if (!sel) begin
            if (low_cnt_r != 5'(sec_pkg::CSL_MIN_CYC - 1)) low_cnt_r <= low_cnt_r + 5'h01;
            else low_ok_r <= 1'b1;
         end else begin
            low_cnt_r <= 5'h00;
         end
         if (launch) begin
            pend_r   <= 1'b1;
            low_ok_r <= 1'b0;
         end else if (pend_r && sel_fall && st_r != sec_pkg::ST_IDLE) begin
            pend_r <= 1'b0;                                // [R3]
         end
         if (sel_fall) stat_r <= 1'b0;                     // [R25]
         else if (sel_rise && pend_r && low_ok_r) stat_r <= 1'b1;      // [R2] [R21]
         else if (start_seen) stat_r <= stat_r;
      end
   end

   // Program requests pass the two-entry buffer; array runs to completion [R15]
   sec_buf #(.W(17)) u_buf (
      .clk       (MCLK),
      .rst       (RST),
      .in_valid  (q_valid_r),
      .in_ready  (buf_ready),
      .in_data   ({q_kind_r, q_addr_r, q_data_r}),
      .out_valid (buf_valid),
      .out_ready (arr_q.ready),
      .out_data  (buf_out)
   );
   assign arr_q.valid = buf_valid;
   assign arr_q.kind  = sec_pkg::sec_prog_t'(buf_out[16:15]);
   assign arr_q.addr  = buf_out[14:8];
   assign arr_q.data  = buf_out[7:0];

   sec_array #(.TWC(TWC), .TEC(TEC), .TWL(TWL), .NODE_ADDR(NODE_ADDR)) u_arr (
      .clk     (MCLK),
      .rst     (RST),
      .wr      (arr_q),
      .rd_addr (raddr_r),
      .rd_data (rd_data),
      .busy    (arr_busy)
   );

   // Busy counts also while a request waits in the buffer
   wire busy_all = arr_busy || buf_valid || q_valid_r;
   // Output: read data, or status (0 busy, 1 ready), else released
   assign SERIAL_OUT      = rd_drv_r ? rsh_r[8] : !busy_all;  // [R2]
   assign SERIAL_OUT_OE_N = !(sel && (rd_drv_r || stat_r));   // [R25] [R21]
endmodule

// *** sec_engine_asserts.sv ***
// Checker of the serial output timing of the command engine
`timescale 1ns/1ps
module sec_engine_asserts #(
   parameter int TWL = 50
) (
   // System
   input wire logic MCLK,
   input wire logic RST,
   // Link
   input wire logic SEL,
   input wire logic SCLK,
   input wire logic SERIAL_IN,
   input wire logic SERIAL_OUT,
   input wire logic SERIAL_OUT_OE_N
);
   logic       sclk_q_r;  // Last link clock level
   logic       sel_q_r;   // Last select level
   logic [3:0] rise_r;    // Cycles since link clock rose
   logic [3:0] selr_r;    // Cycles since select rose
   int         busy_r;    // Cycles of busy level with idle clock
   // Ages saturate so that long idle spans never wrap back to zero
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         sclk_q_r <= 1'b0;
         sel_q_r  <= 1'b0;
         rise_r   <= 4'hf;
         selr_r   <= 4'hf;
         busy_r   <= 0;
      end else begin
         sclk_q_r <= SCLK;
         sel_q_r  <= SEL;
         rise_r   <= (SCLK && !sclk_q_r) ? 4'h0 : (rise_r == 4'hf) ? rise_r : rise_r + 4'h1;
         selr_r   <= (SEL && !sel_q_r) ? 4'h0 : (selr_r == 4'hf) ? selr_r : selr_r + 4'h1;
         // Busy span counted only while the host waits idle
         busy_r   <= (!SERIAL_OUT_OE_N && !SERIAL_OUT && SEL && rise_r == 4'hf) ? busy_r + 1 : 0;
      end
   end
   a_release_on_deselect: assert property (@(posedge MCLK) disable iff (RST)
      $fell(SEL) |-> ##[1:5] SERIAL_OUT_OE_N) else $error("output kept after deselect");
   a_low_sel_quiet: assert property (@(posedge MCLK) disable iff (RST)
      !SEL [*5] |-> SERIAL_OUT_OE_N) else $error("output driven while deselected");
   a_bit_moves_rise: assert property (@(posedge MCLK) disable iff (RST)
      $fell(SERIAL_OUT) && !SERIAL_OUT_OE_N && $past(!SERIAL_OUT_OE_N) |-> rise_r <= 4'h8)
      else $error("read bit moved away from clock rise");
   a_drive_has_cause: assert property (@(posedge MCLK) disable iff (RST)
      $fell(SERIAL_OUT_OE_N) |-> rise_r <= 4'h8 || selr_r <= 4'h8)
      else $error("output driven without cause");
   a_drive_needs_select: assert property (@(posedge MCLK) disable iff (RST)
      $fell(SERIAL_OUT_OE_N) |-> SEL && $past(SEL, 2)) else $error("driven while deselected");
   a_reset_quiet: assert property (@(posedge MCLK) disable iff (RST)
      $fell(RST) |-> SERIAL_OUT_OE_N [*3]) else $error("output driven after reset");
   a_dummy_first: assert property (@(posedge MCLK) disable iff (RST)
      $fell(SERIAL_OUT_OE_N) && selr_r == 4'hf |-> !SERIAL_OUT) else $error("no leading zero");
   a_busy_bounded: assert property (@(posedge MCLK) disable iff (RST)
      busy_r <= TWL) else $error("busy level lasts too long");
endmodule
bind sec_engine sec_engine_asserts #(.TWL(TWL)) u_sec_chk (
   .MCLK            (MCLK),
   .RST             (RST),
   .SEL             (SEL),
   .SCLK            (SCLK),
   .SERIAL_IN       (SERIAL_IN),
   .SERIAL_OUT      (SERIAL_OUT),
   .SERIAL_OUT_OE_N (SERIAL_OUT_OE_N)
);

// *** sec_host.sv ***
// Host controller model driving select, link clock and serial data
`timescale 1ns/1ps
module sec_host (
   // System
   input  wire logic mclk,
   // Link
   output logic      sel,
   output logic      sclk,
   output logic      serial_in,
   input  wire logic serial_out,
   input  wire logic serial_out_oe_n
);
   int   lo   = 6;     // Low phase, raised to pause the clock
   logic ph   = 1'b0;  // Toggle for a 125 ns average period
   logic last = 1'b0;  // Last level seen on the wire
   // Idle link at time zero
   initial begin
      sel       = 1'b0;
      sclk      = 1'b0;
      serial_in = 1'b0;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // No pull on the wire: a released line reads as the inverse of the last level
   function automatic logic pin();
      return serial_out_oe_n ? ~last : serial_out;
   endfunction
   // One link clock; data set in the low phase, sampled before the rise
   task automatic bit_clk(input logic b, output logic s);
      serial_in <= b;
      sclk      <= 1'b0;
      cyc(lo);
      s = pin();
      last = s;
      sclk <= 1'b1;
      cyc(6 + ph);
      ph = ~ph;
   endtask
   task automatic drop();
      sel       <= 1'b0;
      serial_in <= 1'b0;
      cyc(26);            // 260 ns low between commands
   endtask
   task automatic frame(input logic [17:0] b, input int n, input int pre, input int ex,
                        output logic [63:0] rx);
      logic s;
      rx = '0;
      sel <= 1'b1;        // Clock and data low as select rises
      cyc(8);
      repeat (pre) bit_clk(1'b0, s);
      for (int i = 0; i < n; i++) bit_clk(b[17-i], s);   // Exact count
      repeat (ex) begin
         bit_clk(1'b0, s);
         rx = {rx[62:0], s};
      end
      sclk <= 1'b0;
      cyc(2);
      drop();
   endtask
   // Raise select and look at the status
   task automatic stat(output logic oe_n, output logic lvl);
      sel <= 1'b1;
      cyc(8);
      oe_n = serial_out_oe_n;
      lvl  = serial_out;
   endtask
   // Start bit then deselect clears the status
   task automatic clr();
      logic s;
      bit_clk(1'b1, s);
      sclk <= 1'b0;
      cyc(2);
      drop();
   endtask
endmodule

// *** tb.sv ***
// Self-checking bench of the serial EEPROM command engine
`timescale 1ns/1ps
module tb;
   localparam int          TWC  = 200;                  // Shortened program times
   localparam int          TEC  = 300;
   localparam int          TWL  = 400;
   localparam logic [47:0] NODE = 48'h0a0b0c_010203;    // Arbitrary value
   logic mclk = 1'b0;     // System clock
   logic rst  = 1'b1;     // Reset
   logic sel;             // Link lines from the host
   logic sclk;
   logic serial_in;
   logic serial_out;      // Link lines from the engine
   logic serial_out_oe_n;
   int   failures        = 0;
   int   samples_checked = 0;
   always #5 mclk = ~mclk;
   sec_engine #(.TWC(TWC), .TEC(TEC), .TWL(TWL), .NODE_ADDR(NODE)) dut (
      .MCLK(mclk), .RST(rst), .SEL(sel), .SCLK(sclk), .SERIAL_IN(serial_in),
      .SERIAL_OUT(serial_out), .SERIAL_OUT_OE_N(serial_out_oe_n));
   sec_host host (.mclk(mclk), .sel(sel), .sclk(sclk), .serial_in(serial_in),
      .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n));
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("compares %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   function automatic logic [17:0] cmd(input logic [1:0] op, input logic [6:0] a,
                                       input logic [7:0] d);
      return {1'b1, op, a, d};
   endfunction
   task automatic sc(input logic [1:0] op, input logic [6:0] a);
      logic [63:0] rx;
      host.frame(cmd(op, a, 8'h00), 10, 0, 0, rx);
   endtask
   task automatic lc(input logic [1:0] op, input logic [6:0] a, input logic [7:0] d);
      logic [63:0] rx;
      host.frame(cmd(op, a, d), 18, 0, 0, rx);
   endtask
   task automatic rd(input logic [6:0] a, input int nb, output logic [63:0] rx);
      host.frame(cmd(sec_pkg::OPC_READ, a, 8'h00), 10, 0, 8 * nb + 1, rx);
   endtask
   // Status poll: busy first, ready inside the window, then cleared
   task automatic wt(input int lo, input int hi);
      logic oe_n;
      logic lvl;
      int   n;
      n = 0;
      host.stat(oe_n, lvl);
      chk({oe_n, lvl}, 2'b00);
      while (lvl !== 1'b1 && n < hi + 20) begin
         @(posedge mclk);
         lvl = serial_out;
         n++;
      end
      chk(n >= lo && n <= hi, 1'b1);
      chk(serial_out_oe_n, 1'b0);
      host.clr();
   endtask
   task automatic t_factory();
      logic [63:0] rx;
      host.frame(cmd(sec_pkg::OPC_READ, 7'h00, 8'h00), 10, 3, 57, rx);
      chk(rx[56], 1'b0);
      chk(rx[55:48], sec_pkg::PROGRAMMED_MARKER);
      chk(rx[47:0], NODE);
   endtask
   task automatic t_locked();
      logic oe_n;
      logic lvl;
      logic [63:0] rx;
      sc(sec_pkg::OPC_ERASE, 7'h05);
      lc(sec_pkg::OPC_WRITE, 7'h04, 8'h77);
      host.stat(oe_n, lvl);
      chk(oe_n, 1'b1);
      host.drop();
      rd(7'h04, 2, rx);
      chk(rx[16:0], {1'b0, NODE[23:8]});
   endtask
   task automatic t_write();
      logic oe_n;
      logic lvl;
      logic [63:0] rx;
      sc(sec_pkg::OPC_SPECIAL, {sec_pkg::SPC_UNLOCK, 5'h00});
      lc(sec_pkg::OPC_WRITE, 7'h05, 8'h3c);
      wt(TWC - 60, TWC);
      host.stat(oe_n, lvl);
      chk(oe_n, 1'b1);
      host.drop();
      host.lo = 40;
      rd(7'h04, 2, rx);
      host.lo = 6;
      chk(rx[16:0], {1'b0, NODE[23:16], 8'h3c});
   endtask
   task automatic t_quiet();
      logic oe_n;
      logic lvl;
      logic [63:0] rx;
      sc(sec_pkg::OPC_ERASE, 7'h05);
      host.cyc(TWC + 20);
      host.stat(oe_n, lvl);
      chk({oe_n, lvl}, 2'b01);
      host.clr();
      rd(7'h05, 1, rx);
      chk(rx[8:0], {1'b0, sec_pkg::ERASED_BYTE});
   endtask
   task automatic t_fill_wrap();
      logic [63:0] rx;
      lc(sec_pkg::OPC_SPECIAL, {sec_pkg::SPC_FILL_ALL, 5'h00}, 8'h5a);
      wt(TWL - 60, TWL);
      lc(sec_pkg::OPC_WRITE, 7'h00, 8'h11);
      wt(TWC - 60, TWC);
      rd(7'h7f, 3, rx);
      chk(rx[24:0], {1'b0, 24'h5a115a});
   endtask
   task automatic t_clear_lock();
      logic oe_n;
      logic lvl;
      logic [63:0] rx;
      sc(sec_pkg::OPC_SPECIAL, {sec_pkg::SPC_ERASE_ALL, 5'h00});
      wt(TEC - 60, TEC);
      sc(sec_pkg::OPC_SPECIAL, {sec_pkg::SPC_LOCK, 5'h00});
      lc(sec_pkg::OPC_WRITE, 7'h02, 8'h00);
      host.stat(oe_n, lvl);
      chk(oe_n, 1'b1);
      host.drop();
      rd(7'h01, 2, rx);
      chk(rx[16:0], {1'b0, 16'hffff});
   endtask
   // Main sequence; the array loads its contents after reset
   initial begin
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      repeat (140) @(posedge mclk);
      t_factory();
      t_locked();
      t_write();
      t_quiet();
      t_fill_wrap();
      t_clear_lock();
      end_sim();
   end
   // Watchdog far beyond the expected run of some 7500 cycles
   initial begin
      repeat (60000) @(posedge mclk);
      failures++;
      end_sim();
   end
endmodule
